// File: dv/fsu_selector_chk.sv
/*
 * Port checker for the protocol selector.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module fsu_selector_chk
(
    input wire logic clk,
    input wire logic srst,
    input wire fsu_pkg::fsu_apb_req_t apb_req,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] pin_oe,
    input wire logic [2:0] sub_enable,
    input wire logic [2:0] sub_wr,
    input wire logic [2:0] sub_rd,
    input wire logic shared_irq,
    input wire logic dma_tx_req,
    input wire logic dma_rx_req,
    input wire logic clk_req
);
    import fsu_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_access;
        apb_req.psel && apb_req.penable;
    endsequence
    property p_answer;
        s_setup ##1 s_access |-> ##[0:2] pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_onehot;
        $onehot0(sub_enable);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two enabled");
    property p_wr_live;
        (sub_wr & ~sub_enable) == 3'h0;
    endproperty
    a_wr_live: assert property (p_wr_live) else $error("dead write");
    property p_rd_live;
        (sub_rd & ~sub_enable) == 3'h0;
    endproperty
    a_rd_live: assert property (p_rd_live) else $error("dead read");
    property p_strobe;
        sub_rd != 3'h0 |=> sub_rd == 3'h0;
    endproperty
    a_strobe: assert property (p_strobe) else $error("long strobe");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_idle;
        (sub_enable == 3'h0) [*2] |->
            pin_oe == 5'h00 && !shared_irq && !dma_tx_req && !dma_rx_req;
    endproperty
    a_idle: assert property (p_idle) else $error("idle drive");
    property p_clkreq;
        clk_req |-> sub_enable != 3'h0 || $past(sub_enable) != 3'h0;
    endproperty
    a_clkreq: assert property (p_clkreq) else $error("stray request");
endmodule

bind fsu_serial_protocol_selector fsu_selector_chk u_chk (.clk, .srst,
    .apb_req, .pready, .pslverr, .pin_oe, .sub_enable, .sub_wr, .sub_rd,
    .shared_irq, .dma_tx_req, .dma_rx_req, .clk_req);

// File: dv/fsu_sub_model.sv
/*
 * Behavioural model of one serial submodule behind the selector.
 * Assumes the selector's clock and its one-cycle window read strobe.
 */
`timescale 1ns/1ps

module fsu_sub_model
#(
    parameter int ID = 1
)
(
    input wire logic clk,
    input wire logic rd,
    input wire logic [2:0] ev,
    output fsu_pkg::fsu_sub_out_t so,
    output logic [31:0] rdata
);
    import fsu_pkg::*;
    // Each instance shows its own pin pattern so a wrong mux shows up.
    // The clock request is always raised while the submodule wants to run.
    assign so = '{'{5'(ID * 7), 5'(ID * 5 + 1)}, ev[2], ev[1], ev[0], 1'b1,
        16'(ID * 16'h1111), 16'(ID * 16'h1111)};
    // Read data stands while the strobe is high; otherwise it shows the
    // inverse, so a read taken at the wrong edge shows up.
    assign rdata = rd ? 32'(ID) * 32'h01010101 : ~(32'(ID) * 32'h01010101);
endmodule

// File: dv/fsu_tb.sv
/*
 * Self-checking bench for the protocol selector with three models.
 * Assumes the clock runs throughout, as the power manager must allow.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) tests_run++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end

module testbench;
    import fsu_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    fsu_apb_req_t req = '0;
    logic [2:0] ev = 3'h0;
    logic [4:0] pin_in = 5'h0A;
    logic [31:0] rdat, prdata;
    logic err, pready, pslverr, irq, shirq, dtx, drx, creq;
    logic [4:0] pout, poe;
    logic [2:0] en, rd;
    logic [31:0] rd0, rd1, rd2;
    fsu_sub_out_t so0, so1, so2;
    int failures = 0;
    int tests_run = 0;
    // The clock never stops here, so the wrapper is always usable.
    always #10 clk = ~clk;
    fsu_sub_model #(.ID(1)) m0 (.clk, .rd(rd[0]), .ev, .so(so0), .rdata(rd0));
    fsu_sub_model #(.ID(2)) m1 (.clk, .rd(rd[1]), .ev, .so(so1), .rdata(rd1));
    fsu_sub_model #(.ID(3)) m2 (.clk, .rd(rd[2]), .ev, .so(so2), .rdata(rd2));
    fsu_serial_protocol_selector uut (.clk, .srst, .apb_req(req), .prdata,
        .pready, .pslverr, .serial_out(so0), .spi_out(so1), .twb_out(so2),
        .serial_rdata(rd0), .spi_rdata(rd1), .twb_rdata(rd2), .pin_in,
        .pin_out(pout), .pin_oe(poe), .sub_pin_in(), .sub_enable(en),
        .sub_wr(), .sub_rd(rd), .sub_addr(), .sub_wdata(),
        .tx_mirror_wr_data(), .tx_mirror_wr(), .irq, .shared_irq(shirq),
        .dma_tx_req(dtx), .dma_rx_req(drx), .clk_req(creq));

    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (!pready && n++ < 20);
        if (!pready)
            failures++;
        rdat = prdata;
        err = pslverr;
        req <= '0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial
    begin
        logic [11:0] a;
        logic bad;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        xfer(0, 12'h000, 0);
        `CHK("mode reset", 32'h0, rdat)
        for (int m = 0; m < 4; m++)
        begin
            xfer(1, 12'h000, 32'(m));
            xfer(0, 12'h000, 0);
            `CHK("mode", 32'(m), rdat)
            `CHK("enable", (m == 0) ? 3'h0 : 3'(1 << (m - 1)), en)
            `CHK("oe", (m == 0) ? 5'h00 : 5'(m * 5 + 1), poe)
            `CHK("out", (m == 0) ? 5'h00 : 5'(m * 7), pout)
            for (int w = 0; w < 3; w++)
            begin
                for (int k = 0; k < 3; k++)
                begin
                    a = 12'h200 + 12'(w) * 12'h200 + 12'(k) * 12'h094;
                    bad = (m != w + 1);
                    xfer(1, a, 32'h0);
                    `CHK("wr err", bad, err)
                    xfer(0, a, 0);
                    `CHK("rd err", bad, err)
                    `CHK("rd data", bad ? 32'h0 : 32'(w + 1) * 32'h01010101,
                        rdat)
                end
            end
            xfer(0, 12'h010, 0);
            if (m != 0)
            begin
                `CHK("rx mirror", 32'(m) * 32'h1111, rdat)
            end
            ev <= 3'h7;
            repeat (3) @(posedge clk);
            `CHK("events", (m == 0) ? 3'h0 : 3'h7, {shirq, dtx, drx})
            ev <= 3'h0;
            repeat (2) @(posedge clk);
            xfer(0, 12'h030, 0);
            `CHK("status", (m == 0) ? 32'h0 : 32'h7, rdat)
            $display("mode %0d done", m);
        end
        xfer(1, 12'h034, 32'h1);
        ev <= 3'h1;
        repeat (4) @(posedge clk);
        `CHK("masked irq", 1'b0, irq)
        ev <= 3'h2;
        repeat (4) @(posedge clk);
        ev <= 3'h0;
        `CHK("irq", 1'b1, irq)
        xfer(0, 12'h030, 0);
        `CHK("status", 32'h3, rdat)
        repeat (2) @(posedge clk);
        `CHK("irq clear", 1'b0, irq)
        xfer(0, 12'h004, 0);
        `CHK("unmapped", 1'b1, err)
        `CHK("clk req off", 1'b0, creq)
        xfer(1, 12'h038, 32'h1);
        repeat (3) @(posedge clk);
        `CHK("clk req", 1'b1, creq)
        $display("irq and wake done");
        report_and_stop();
    end
endmodule

// File: rtl/fsu_params.svh
/*
 * Register offsets, field positions and reset values of the flexible
 * serial unit wrapper. Assumes byte addressing on a 32-bit APB bus.
 */
`ifndef FSU_PARAMS_SVH
`define FSU_PARAMS_SVH

`define FSU_PROTOCOL_SELECT_OFS 12'h000
`define FSU_RX_MIRROR_OFS 12'h010
`define FSU_TX_MIRROR_OFS 12'h020
`define FSU_IRQ_STATUS_OFS 12'h030
`define FSU_IRQ_MASK_OFS 12'h034
`define FSU_WAKE_CTRL_OFS 12'h038
`define FSU_PROTOCOL_RESET 2'h0
`define FSU_MODE_LSB 0
`define FSU_MODE_MSB 1
`define FSU_SERIAL_LO 12'h200
`define FSU_SERIAL_HI 12'h2FC
`define FSU_SERIAL_DMA_LO 12'h300
`define FSU_SERIAL_DMA_HI 12'h328
`define FSU_SPI_LO 12'h400
`define FSU_SPI_HI 12'h4FC
`define FSU_SPI_DMA_LO 12'h500
`define FSU_SPI_DMA_HI 12'h528
`define FSU_TWB_LO 12'h600
`define FSU_TWB_HI 12'h6FC
`define FSU_TWB_DMA_LO 12'h700
`define FSU_TWB_DMA_HI 12'h728

`endif

// File: rtl/fsu_pkg.sv
/*
 * Types of the flexible serial unit wrapper.
 * Assumes the offsets and reset values come from fsu_params.svh.
 */
package fsu_pkg;

    typedef enum logic [1:0]
    {
        FSU_NO_PROTOCOL = 2'h0,
        FSU_SERIAL_PORT = 2'h1,
        FSU_SPI = 2'h2,
        FSU_TWO_WIRE_BUS = 2'h3
    } fsu_mode_t;

    // Five shared I/O lines, each with output and enable.
    typedef struct packed
    {
        logic [4:0] out;
        logic [4:0] oe;
    } fsu_pin_drive_t;

    // What one submodule hands to the wrapper.
    typedef struct packed
    {
        fsu_pin_drive_t pins;
        logic irq;
        logic dma_tx_req;
        logic dma_rx_req;
        logic clk_req;
        logic [15:0] transmit_word;
        logic [15:0] receive_word;
    } fsu_sub_out_t;

    // APB request as seen by the slave.
    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fsu_apb_req_t;

endpackage

// File: rtl/fsu_serial_protocol_selector.sv
/*
 * Flexible serial unit wrapper: APB slave with the protocol selector,
 * pin, interrupt and DMA trigger multiplexers and data mirrors.
 * Assumes three submodules on the inner side whose register windows are
 * forwarded here, and a power manager that gates clk.
 */
// Register access over APB is this design's own decision.
// Summary of operation
// - At most one of the three submodules is enabled, chosen by the mode.
// - Pins, interrupts and events reach the shared side only from the selected one.
// - Unselected submodules stay disabled and writes to them are dropped.
// - One interrupt output and one DMA channel set are driven by the selected one.
// - Mode bits 1:0 decode as none, serial port, SPI and two-wire bus.
// - In mode 1 the SPI and two-wire windows are unreachable and off the pins.
// - In mode 2 the serial-port and two-wire windows are unreachable and off the pins.
// - In mode 3 the serial-port and SPI windows are unreachable and off the pins.
// - With partial wakeup enabled the wrapper raises clock requests to the power manager.
// - Serial-port windows decode at 0x200-0x2FC and 0x300-0x328.
// - SPI windows decode at 0x400-0x4FC and 0x500-0x528.
// - Two-wire windows decode at 0x600-0x6FC and 0x700-0x728.
// - The holding mirrors follow the selected submodule's data registers.
`timescale 1ns/1ps
`include "fsu_params.svh"

module fsu_serial_protocol_selector
(
    input wire logic clk,
    input wire logic srst,
    input wire fsu_pkg::fsu_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fsu_pkg::fsu_sub_out_t serial_out,
    input wire fsu_pkg::fsu_sub_out_t spi_out,
    input wire fsu_pkg::fsu_sub_out_t twb_out,
    input wire logic [31:0] serial_rdata,
    input wire logic [31:0] spi_rdata,
    input wire logic [31:0] twb_rdata,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [4:0] sub_pin_in,
    output logic [2:0] sub_enable,
    output logic [2:0] sub_wr,
    output logic [2:0] sub_rd,
    output logic [9:0] sub_addr,
    output logic [31:0] sub_wdata,
    output logic [15:0] tx_mirror_wr_data,
    output logic tx_mirror_wr,
    output logic irq,
    output logic shared_irq,
    output logic dma_tx_req,
    output logic dma_rx_req,
    output logic clk_req
);
    import fsu_pkg::*;

    fsu_mode_t mode_q;
    logic wake_en_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic [4:0] pin_sync1_q;
    logic [4:0] pin_sync2_q;
    logic sub_irq_prev_q;
    fsu_sub_out_t sel;
    logic [11:0] addr;
    logic setup;
    logic [2:0] win_hit;
    logic [2:0] win_sel;
    logic [2:0] events;
    logic mapped;

    assign addr = apb_req.paddr;
    assign setup = apb_req.psel & ~apb_req.penable;

    // Window decode per submodule.
    assign win_hit[0] = (addr >= `FSU_SERIAL_LO && addr <= `FSU_SERIAL_HI)
        || (addr >= `FSU_SERIAL_DMA_LO && addr <= `FSU_SERIAL_DMA_HI);
    assign win_hit[1] = (addr >= `FSU_SPI_LO && addr <= `FSU_SPI_HI)
        || (addr >= `FSU_SPI_DMA_LO && addr <= `FSU_SPI_DMA_HI);
    assign win_hit[2] = (addr >= `FSU_TWB_LO && addr <= `FSU_TWB_HI)
        || (addr >= `FSU_TWB_DMA_LO && addr <= `FSU_TWB_DMA_HI);

    // A window is live only for the selected protocol.
    assign win_sel[0] = win_hit[0] && mode_q == FSU_SERIAL_PORT;
    assign win_sel[1] = win_hit[1] && mode_q == FSU_SPI;
    assign win_sel[2] = win_hit[2] && mode_q == FSU_TWO_WIRE_BUS;

    assign mapped = addr == `FSU_PROTOCOL_SELECT_OFS
        || addr == `FSU_RX_MIRROR_OFS || addr == `FSU_TX_MIRROR_OFS
        || addr == `FSU_IRQ_STATUS_OFS || addr == `FSU_IRQ_MASK_OFS
        || addr == `FSU_WAKE_CTRL_OFS || (|win_sel);

    // Selected submodule's outputs; mode 0 selects nothing.
    always_comb
    begin
        sel = '0;
        case (mode_q)
            FSU_SERIAL_PORT: sel = serial_out;
            FSU_SPI: sel = spi_out;
            FSU_TWO_WIRE_BUS: sel = twb_out;
            default: sel = '0;
        endcase
    end

    // Interrupt sources: selected submodule's line and its two DMA triggers.
    assign events = {sel.irq & ~sub_irq_prev_q, sel.dma_rx_req,
        sel.dma_tx_req};

    // Mode register; in mode 0 no submodule is enabled or routed, but the APB registers stay live.
    always_ff @(posedge clk)
    begin
        if (srst)
            mode_q <= fsu_mode_t'(`FSU_PROTOCOL_RESET);
        else if (apb_req.psel && apb_req.penable && apb_req.pwrite
            && addr == `FSU_PROTOCOL_SELECT_OFS)
            mode_q <= fsu_mode_t'(
                apb_req.pwdata[`FSU_MODE_MSB:`FSU_MODE_LSB]);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wake_en_q <= 1'b0;
            irq_mask_q <= 3'h0;
        end
        else if (apb_req.psel && apb_req.penable && apb_req.pwrite)
        begin
            if (addr == `FSU_WAKE_CTRL_OFS)
                wake_en_q <= apb_req.pwdata[0];
            if (addr == `FSU_IRQ_MASK_OFS)
                irq_mask_q <= apb_req.pwdata[2:0];
        end
    end

    // Sticky status, cleared by read; a new event wins over the clear.
    always_ff @(posedge clk)
    begin
        if (srst)
            irq_status_q <= 3'h0;
        else if (apb_req.psel && apb_req.penable && !apb_req.pwrite
            && !pready && addr == `FSU_IRQ_STATUS_OFS)
            // Clear only at the edge that captures the read data, so an
            // event landing while pready is up is not lost.
            irq_status_q <= events;
        else
            irq_status_q <= irq_status_q | events;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            sub_irq_prev_q <= 1'b0;
        else
            sub_irq_prev_q <= sel.irq;
    end

    // Pins come from outside the clock domain.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_sync1_q <= 5'h00;
            pin_sync2_q <= 5'h00;
        end
        else
        begin
            pin_sync1_q <= pin_in;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // Shared pins, interrupt, DMA and submodule enables.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_out <= 5'h00;
            pin_oe <= 5'h00;
            sub_pin_in <= 5'h00;
            sub_enable <= 3'h0;
            shared_irq <= 1'b0;
            dma_tx_req <= 1'b0;
            dma_rx_req <= 1'b0;
            irq <= 1'b0;
            clk_req <= 1'b0;
        end
        else
        begin
            pin_out <= sel.pins.out;
            pin_oe <= sel.pins.oe;
            sub_pin_in <= pin_sync2_q;
            sub_enable <= {mode_q == FSU_TWO_WIRE_BUS, mode_q == FSU_SPI,
                mode_q == FSU_SERIAL_PORT};
            shared_irq <= sel.irq;
            dma_tx_req <= sel.dma_tx_req;
            dma_rx_req <= sel.dma_rx_req;
            irq <= |((irq_status_q | events) & irq_mask_q);
            // Requests go out only when wakeup is allowed.
            clk_req <= wake_en_q & sel.clk_req;
        end
    end

    // Forward accesses to the live window only.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sub_wr <= 3'h0;
            sub_rd <= 3'h0;
            sub_addr <= 10'h000;
            sub_wdata <= 32'h0000_0000;
            tx_mirror_wr <= 1'b0;
            tx_mirror_wr_data <= 16'h0000;
        end
        else
        begin
            sub_wr <= (setup && apb_req.pwrite) ? win_sel : 3'h0;
            sub_rd <= (setup && !apb_req.pwrite) ? win_sel : 3'h0;
            sub_addr <= addr[9:0];
            sub_wdata <= apb_req.pwdata;
            // Mirror write reaches the selected data register.
            tx_mirror_wr <= setup && apb_req.pwrite
                && addr == `FSU_TX_MIRROR_OFS
                && mode_q != FSU_NO_PROTOCOL;
            tx_mirror_wr_data <= apb_req.pwdata[15:0];
        end
    end

    // One wait state: data from submodule windows settles in setup+1.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (apb_req.psel && apb_req.penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= 32'h0000_0000;
            if (!apb_req.pwrite)
            begin
                case (addr)
                    `FSU_PROTOCOL_SELECT_OFS:
                        prdata <= {30'h0000_0000, mode_q};
                    `FSU_RX_MIRROR_OFS:
                        prdata <= {16'h0000, sel.receive_word};
                    `FSU_TX_MIRROR_OFS:
                        prdata <= {16'h0000, sel.transmit_word};
                    `FSU_IRQ_STATUS_OFS:
                        prdata <= {29'h0000_0000, irq_status_q};
                    `FSU_IRQ_MASK_OFS:
                        prdata <= {29'h0000_0000, irq_mask_q};
                    `FSU_WAKE_CTRL_OFS:
                        prdata <= {31'h0000_0000, wake_en_q};
                    default:
                    begin
                        // Dead windows read zero with an error.
                        if (win_sel[0])
                            prdata <= serial_rdata;
                        else if (win_sel[1])
                            prdata <= spi_rdata;
                        else if (win_sel[2])
                            prdata <= twb_rdata;
                    end
                endcase
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
